// File: src/dpm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module dpm_ctrl
    import dpm_pkg::*;
#(
    parameter int PWRUP_CYCLES = dpm_pkg::PWRUP_CYC,
    parameter int REFRESH_CYCLES = dpm_pkg::REF_IVL_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // user request
    input wire logic req_valid_i,
    input wire dpm_pkg::dpm_req_type req_i,
    output logic req_ready_o,
    // user answer
    output logic rvalid_o,
    output logic rdata_o,
    output logic init_done_o,
    // memory pins
    output dpm_pkg::dpm_pins_type pins_o,
    input wire logic dout_i
);

    import dpm_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dpm_state_type state_q, state_d;
    dpm_pins_type pins_q, pins_d;
    dpm_req_type req_q, req_d;
    logic ready_q, ready_d;
    logic rvalid_q, rvalid_d;
    logic rdata_q, rdata_d;
    logic due_q, due_d;
    logic init_done_q, init_done_d;
    logic [3:0] init_cnt_q, init_cnt_d;
    logic page_q, page_d;
    logic pend_q, pend_d;
    logic tmr_load, tmr_done;
    logic [TMR_W-1:0] tmr_val;
    logic ref_load, ref_done;
    logic [REF_W-1:0] ref_val;
    logic page_hit;

    // strobe spacing timer
    dpm_wait #(.W(TMR_W)) u_tmr (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .load_i(tmr_load),
        .value_i(tmr_val),
        .done_o(tmr_done)
    );

    // power-up pause, then refresh interval
    dpm_wait #(.W(REF_W)) u_ref (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .load_i(ref_load),
        .value_i(ref_val),
        .done_o(ref_done)
    );

    // a page column only for reads in the open row, never when refresh waits
    assign page_hit = (req_i.op == OP_READ) && (req_i.row == req_q.row) && !due_q;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // next-state logic for strobes, timers and refresh bookkeeping
    always_comb begin
        state_d = state_q;
        pins_d = pins_q;
        req_d = req_q;
        rvalid_d = 1'h0;
        rdata_d = rdata_q;
        due_d = due_q;
        init_done_d = init_done_q;
        init_cnt_d = init_cnt_q;
        page_d = page_q;
        pend_d = pend_q;
        tmr_load = 1'h0;
        tmr_val = '0;
        ref_load = 1'h0;
        ref_val = REF_W'(REFRESH_CYCLES - 1);
        case (state_q)
            ST_RESET: begin
                // strobes stay high through the whole pause
                ref_load = 1'h1;
                ref_val = REF_W'(PWRUP_CYCLES - 1);
                state_d = ST_PWRUP;
            end
            ST_PWRUP: begin
                if (ref_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // a due refresh goes before a request: in idle, ready is held low while refresh is due
                if (req_valid_i && ready_q) begin
                    req_d = req_i;
                    page_d = 1'h0;
                    pins_d.ras_n = 1'h0;
                    pins_d.addr = {1'h0, req_i.row}; // row latched, column high
                    state_d = ST_ROW;
                    tmr_load = 1'h1;
                    tmr_val = W_RAH;
                end else if (due_q || !init_done_q) begin
                    pins_d.cas_n = 1'h0; // column strobe leads
                    state_d = ST_CBR_CAS;
                    tmr_load = 1'h1;
                    tmr_val = W_CSR;
                end
            end
            ST_ROW: begin
                if (tmr_done) begin
                    pins_d.addr = req_q.col;
                    if (req_q.op == OP_WRITE) begin
                        pins_d.we_n = 1'h0; // early write, before column strobe
                        pins_d.din = req_q.wdata;
                    end
                    state_d = ST_COL;
                    tmr_load = 1'h1;
                    tmr_val = W_COL;
                end
            end
            ST_COL: begin
                if (tmr_done) begin
                    pins_d.cas_n = 1'h0;
                    state_d = ST_CAS;
                    tmr_load = 1'h1;
                    tmr_val = page_q ? W_PG : W_ACC;
                end
            end
            ST_CAS: begin
                if (tmr_done) begin
                    if (req_q.op != OP_WRITE) begin
                        rvalid_d = 1'h1;
                        rdata_d = dout_i;
                    end
                    tmr_load = 1'h1;
                    if (req_q.op == OP_RMW) begin
                        // data is sampled on this same edge, so the enable falls after it
                        pins_d.we_n = 1'h0;
                        pins_d.din = req_q.wdata;
                        state_d = ST_WE;
                        tmr_val = W_RWL;
                    end else if (req_q.op == OP_READ && due_q) begin
                        pins_d.ras_n = 1'h1; // column stays low
                        state_d = ST_HID_PRE;
                        tmr_val = W_RP;
                    end else if (req_q.op == OP_READ) begin
                        pins_d.cas_n = 1'h1; // row stays open
                        state_d = ST_OPEN;
                        tmr_val = W_CP;
                    end else begin
                        pins_d = PINS_RST;
                        state_d = ST_PRECHG;
                        tmr_val = W_RP;
                    end
                end
            end
            ST_WE: begin
                if (tmr_done) begin
                    pins_d = PINS_RST;
                    state_d = ST_PRECHG;
                    tmr_load = 1'h1;
                    tmr_val = W_RP;
                end
            end
            ST_OPEN: begin
                if (tmr_done) begin
                    state_d = ST_PAGE;
                end
            end
            ST_PAGE: begin
                // any offered request is taken; a miss waits for the precharge
                tmr_load = 1'h1;
                if (req_valid_i) begin
                    req_d = req_i;
                end
                if (req_valid_i && page_hit) begin
                    pins_d.addr = req_i.col; // new column, same row
                    page_d = 1'h1;
                    state_d = ST_COL;
                    tmr_val = W_ASC;
                end else begin
                    pend_d = req_valid_i;
                    pins_d = PINS_RST;
                    state_d = ST_PRECHG;
                    tmr_val = W_RP;
                end
            end
            ST_PRECHG: begin
                if (tmr_done && pend_q) begin
                    pend_d = 1'h0;
                    page_d = 1'h0;
                    pins_d.ras_n = 1'h0;
                    pins_d.addr = {1'h0, req_q.row};
                    state_d = ST_ROW;
                    tmr_load = 1'h1;
                    tmr_val = W_RAH;
                end else if (tmr_done) begin
                    state_d = ST_IDLE; // standby
                end
            end
            ST_CBR_CAS: begin
                if (tmr_done) begin
                    pins_d.ras_n = 1'h0; // no row address needed
                    state_d = ST_CBR_RAS;
                    tmr_load = 1'h1;
                    tmr_val = W_RAS;
                end
            end
            ST_HID_PRE: begin
                if (tmr_done) begin
                    pins_d.ras_n = 1'h0; // device supplies the row
                    state_d = ST_HID_RAS;
                    tmr_load = 1'h1;
                    tmr_val = W_RAS;
                end
            end
            ST_CBR_RAS, ST_HID_RAS: begin
                if (tmr_done) begin
                    pins_d = PINS_RST;
                    state_d = ST_PRECHG;
                    tmr_load = 1'h1;
                    tmr_val = W_RP;
                    if (!init_done_q) begin
                        init_cnt_d = init_cnt_q + 4'h1;
                        if (init_cnt_q == 4'(INIT_CYCLES - 1)) begin
                            init_done_d = 1'h1;
                            ref_load = 1'h1;
                        end
                    end else begin
                        due_d = 1'h0; // one row per interval
                    end
                end
            end
            default: begin
                state_d = ST_RESET;
                pins_d = PINS_RST;
            end
        endcase
        // interval tick restarts itself; set wins over the clear above
        if (ref_done && init_done_q) begin
            ref_load = 1'h1;
            ref_val = REF_W'(REFRESH_CYCLES - 1);
            due_d = 1'h1;
        end
        ready_d = (state_d == ST_IDLE && init_done_d && !due_d) || state_d == ST_PAGE;
    end

    // registers only
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_RESET;
            pins_q <= PINS_RST;
            req_q <= '0;
            ready_q <= 1'h0;
            rvalid_q <= 1'h0;
            rdata_q <= 1'h0;
            due_q <= 1'h0;
            init_done_q <= 1'h0;
            init_cnt_q <= '0;
            page_q <= 1'h0;
            pend_q <= 1'h0;
        end else begin
            state_q <= state_d;
            pins_q <= pins_d;
            req_q <= req_d;
            ready_q <= ready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            due_q <= due_d;
            init_done_q <= init_done_d;
            init_cnt_q <= init_cnt_d;
            page_q <= page_d;
            pend_q <= pend_d;
        end
    end

    assign pins_o = pins_q;
    assign req_ready_o = ready_q;
    assign rvalid_o = rvalid_q;
    assign rdata_o = rdata_q;
    assign init_done_o = init_done_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_cbr_start;
        $fell(pins_q.cas_n) && pins_q.ras_n;
    endsequence
    sequence s_cbr_row;
        !pins_q.cas_n && $fell(pins_q.ras_n);
    endsequence
    sequence s_row_open;
        $fell(pins_q.ras_n);
    endsequence

    chk_read_strobes: assert property ((state_q == ST_CAS && req_q.op == OP_READ) |->
        (pins_q.we_n && !pins_q.ras_n && !pins_q.cas_n))
        else $error("read cycle strobes wrong");
    chk_early_write: assert property (($fell(pins_q.cas_n) && req_q.op == OP_WRITE &&
        !pins_q.ras_n) |-> (!pins_q.we_n && $past(!pins_q.we_n)))
        else $error("write enable not low before column strobe");
    chk_rmw_order: assert property (($fell(pins_q.we_n) && req_q.op == OP_RMW) |->
        (rvalid_q && !pins_q.cas_n))
        else $error("write enable fell before read data");
    chk_page_open: assert property ((state_q == ST_PAGE) |->
        (!pins_q.ras_n && pins_q.we_n && pins_q.cas_n))
        else $error("page gap without open row");
    chk_cbr_order: assert property (s_cbr_start |-> ##1 s_cbr_row)
        else $error("row strobe not after column strobe");
    chk_refresh_bound: assert property ($rose(due_q) |-> ##[1:200] !due_q)
        else $error("refresh not served in time");
    chk_pwrup_idle: assert property ((state_q == ST_PWRUP) |->
        (pins_q.ras_n && pins_q.cas_n && !init_done_q))
        else $error("strobes active during power-up pause");
    chk_row_top_bit: assert property (($fell(pins_q.ras_n) && pins_q.cas_n) |->
        (pins_q.addr[ADDR_W-1] == 1'h0))
        else $error("top address pin set for row");
    chk_hidden_cas: assert property ((state_q == ST_HID_PRE || state_q == ST_HID_RAS) |->
        !pins_q.cas_n)
        else $error("column strobe rose during hidden refresh");
    chk_ras_width: assert property (s_row_open |-> !pins_q.ras_n [*8])
        else $error("row strobe pulse too short");

endmodule // dpm_ctrl

`default_nettype wire

// File: src/dpm_pkg.sv
package dpm_pkg;

    // ------------------------------------------------------------
    // clock and address geometry
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int ROW_W = 9;
    localparam int COL_W = 10;
    localparam int ADDR_W = 10;
    localparam int TMR_W = 8;
    localparam int REF_W = 16;
    localparam int INIT_CYCLES = 8;
    localparam int REF_ROWS = 512;

    // ------------------------------------------------------------
    // strobe timing in ns, refresh period in us, one speed grade
    // ------------------------------------------------------------
    localparam int T_RP_NS = 60;
    localparam int T_RAS_NS = 70;
    localparam int T_RAH_NS = 10;
    localparam int T_RCD_NS = 20;
    localparam int T_CAS_NS = 25;
    localparam int T_CP_NS = 10;
    localparam int T_CPA_NS = 53;
    localparam int T_CSR_NS = 0;
    localparam int T_RWL_NS = 22;
    localparam int T_ASC_NS = 0;
    localparam int T_PWRUP_NS = 200000;
    localparam int T_REF_PERIOD_US = 64000;

    // least time: round up, never below one cycle
    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    // longest time: round down; the power-up pause is a least time and rounds up
    localparam int REF_IVL_NS = (T_REF_PERIOD_US * 1000) / REF_ROWS;
    localparam int REF_IVL_CYC = (REF_IVL_NS * CLK_MHZ) / 1000;
    localparam int PWRUP_CYC = ns2cyc(T_PWRUP_NS);

    // wait loads: a state lasts load+1 cycles
    localparam int ACC_CAS_CYC = (ns2cyc(T_CAS_NS) > ns2cyc(T_RAS_NS) - ns2cyc(T_RCD_NS)) ?
        ns2cyc(T_CAS_NS) : ns2cyc(T_RAS_NS) - ns2cyc(T_RCD_NS);
    localparam int PG_CAS_CYC = (ns2cyc(T_CAS_NS) > ns2cyc(T_CPA_NS) - ns2cyc(T_CP_NS)) ?
        ns2cyc(T_CAS_NS) : ns2cyc(T_CPA_NS) - ns2cyc(T_CP_NS);
    localparam logic [TMR_W-1:0] W_RP = TMR_W'(ns2cyc(T_RP_NS) - 1);
    localparam logic [TMR_W-1:0] W_RAS = TMR_W'(ns2cyc(T_RAS_NS) - 1);
    localparam logic [TMR_W-1:0] W_RAH = TMR_W'(ns2cyc(T_RAH_NS) - 1);
    localparam logic [TMR_W-1:0] W_COL = TMR_W'(ns2cyc(T_RCD_NS) - ns2cyc(T_RAH_NS) - 1);
    localparam logic [TMR_W-1:0] W_ACC = TMR_W'(ACC_CAS_CYC - 1);
    localparam logic [TMR_W-1:0] W_PG = TMR_W'(PG_CAS_CYC - 1);
    localparam logic [TMR_W-1:0] W_CP = TMR_W'(ns2cyc(T_CP_NS) - 1);
    localparam logic [TMR_W-1:0] W_CSR = TMR_W'(ns2cyc(T_CSR_NS) - 1);
    localparam logic [TMR_W-1:0] W_RWL = TMR_W'(ns2cyc(T_RWL_NS) - 1);
    localparam logic [TMR_W-1:0] W_ASC = TMR_W'(ns2cyc(T_ASC_NS) - 1);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_RMW = 2'h2
    } dpm_op_type;

    typedef enum logic [13:0] {
        ST_RESET = 14'h0001,
        ST_PWRUP = 14'h0002,
        ST_IDLE = 14'h0004,
        ST_ROW = 14'h0008,
        ST_COL = 14'h0010,
        ST_CAS = 14'h0020,
        ST_WE = 14'h0040,
        ST_OPEN = 14'h0080,
        ST_PAGE = 14'h0100,
        ST_PRECHG = 14'h0200,
        ST_CBR_CAS = 14'h0400,
        ST_CBR_RAS = 14'h0800,
        ST_HID_PRE = 14'h1000,
        ST_HID_RAS = 14'h2000
    } dpm_state_type;

    typedef struct packed {
        dpm_op_type op;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic wdata;
    } dpm_req_type;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic din;
    } dpm_pins_type;

    localparam dpm_pins_type PINS_RST = '{ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1,
                                          addr: '0, din: 1'h0};

endpackage

// File: src/dpm_wait.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// down counter: load a value, done once it reaches zero
// ------------------------------------------------------------
module dpm_wait #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // control
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    // status
    output logic done_o
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    // load wins; otherwise count down and park at zero
    always_comb begin
        count_d = count_q;
        if (load_i) begin
            count_d = value_i;
        end else if (count_q != '0) begin
            count_d = count_q - W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign done_o = (count_q == '0);

endmodule // dpm_wait

`default_nettype wire

// File: dv/dpm_dram_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// behavioural one-bit page mode memory, framed by strobe edges
// ------------------------------------------------------------
module dpm_dram_model
    import dpm_pkg::*;
#(
    parameter int FAST_NS = 5,
    parameter int SLOW_NS = 35
) (
    // memory pins
    input wire dpm_pkg::dpm_pins_type pins_i,
    output logic dout_o,
    // bench control and status
    input wire logic slow_i,
    output int refresh_count_o,
    output int proto_err_o
);
    import dpm_pkg::*;

    logic mem [int];
    logic [ROW_W-1:0] row_q;
    logic [ROW_W-1:0] ref_ctr_q;
    logic last_q;
    logic valid_q;
    int key;

    // unknown start state of a real part: output shows a made-up level
    initial begin
        dout_o = 1'b0;
        last_q = 1'b0;
        valid_q = 1'b0;
        row_q = '0;
        ref_ctr_q = '0;
        refresh_count_o = 0;
        proto_err_o = 0;
    end

    // row strobe falls: column strobe already low picks the internal counter
    always @(negedge pins_i.ras_n) begin
        if (pins_i.cas_n == 1'b0) begin
            ref_ctr_q = ref_ctr_q + 1'b1;
            refresh_count_o = refresh_count_o + 1;
        end else begin
            row_q = pins_i.addr[ROW_W-1:0];
        end
    end

    // column strobe falls inside a row cycle: early write or read
    always @(negedge pins_i.cas_n) begin
        if (pins_i.ras_n == 1'b0) begin
            key = int'({row_q, pins_i.addr});
            if (pins_i.we_n == 1'b0) begin
                mem[key] = pins_i.din;
            end else begin
                // data appears after the access time; input pin ignored
                #(slow_i ? SLOW_NS : FAST_NS);
                if (pins_i.cas_n == 1'b0) begin
                    last_q = mem.exists(key) ? mem[key] : 1'b0;
                    valid_q = 1'b1;
                    dout_o = last_q;
                end
            end
        end
    end

    // late write enable: only legal once read data is out
    always @(negedge pins_i.we_n) begin
        if (pins_i.ras_n == 1'b0 && pins_i.cas_n == 1'b0) begin
            if (valid_q != 1'b1) begin
                proto_err_o = proto_err_o + 1;
            end
            mem[key] = pins_i.din;
        end
    end

    // column strobe rises: data held briefly, then a wrong level, not the old one
    // hidden refresh keeps the column strobe low, so data stays put
    always @(posedge pins_i.cas_n) begin
        valid_q = 1'b0;
        #2;
        if (pins_i.cas_n == 1'b1) begin
            dout_o = ~last_q;
        end
    end

endmodule // dpm_dram_model
`default_nettype wire

// File: dv/dpm_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dpm_ctrl_tb;
    import dpm_pkg::*;

    localparam int REF_CYC = 200;

    logic clk_sys_i;
    logic rstn_i;
    logic req_valid_i;
    dpm_req_type req_i;
    logic req_ready_o;
    logic rvalid_o;
    logic rdata_o;
    logic init_done_o;
    dpm_pins_type pins_o;
    logic dout_i;
    logic slow;
    int refresh_count;
    int proto_err;
    int err_count;
    int checked;
    int seed;
    int cyc;
    int t0;
    logic exp_mem [int];
    logic exp_q [$];
    int rows [4] = '{0, 1, 510, 511};

    dpm_ctrl #(.PWRUP_CYCLES(20), .REFRESH_CYCLES(REF_CYC)) DUT (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .rvalid_o(rvalid_o),
        .rdata_o(rdata_o), .init_done_o(init_done_o), .pins_o(pins_o), .dout_i(dout_i)
    );

    dpm_dram_model mem_model (
        .pins_i(pins_o), .dout_o(dout_i), .slow_i(slow),
        .refresh_count_o(refresh_count), .proto_err_o(proto_err)
    );

    // ------------------------------------------------------------
    // clock, cycle count, checks
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) cyc++;

    task automatic check_bit(input logic exp, input logic got, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic check_int(input int exp, input int got, input string what);
        checked++;
        if (got != exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // offer one request and hold it until taken; reference memory follows
    task automatic send(input dpm_op_type op, input int row, input int col, input logic wd);
        logic rdy;
        int n;
        int key;
        req_i = '{op: op, row: ROW_W'(row), col: COL_W'(col), wdata: wd};
        req_valid_i = 1'b1;
        n = 0;
        key = int'({ROW_W'(row), COL_W'(col)});
        do begin
            @(negedge clk_sys_i);
            rdy = req_ready_o;
            @(posedge clk_sys_i);
            n++;
        end while (rdy !== 1'b1 && n < 2000);
        #1;
        check_bit(1'b0, req_ready_o, "ready after take");
        if (n >= 2000) begin
            err_count++;
            $display("unexpected at %0t: request never taken", $time);
        end
        if (op != OP_WRITE) begin
            exp_q.push_back(exp_mem.exists(key) ? exp_mem[key] : 1'b0);
        end
        if (op != OP_READ) begin
            exp_mem[key] = wd;
        end
    endtask

    // every read answer is matched in order against the reference memory
    always @(negedge clk_sys_i) begin
        if (rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("unexpected at %0t: read answer without request", $time);
            end else begin
                check_bit(exp_q.pop_front(), rdata_o, "read data");
            end
        end
    end

    // hang guard, well beyond the expected run length
    initial begin
        #400000;
        err_count++;
        $display("unexpected at %0t: run did not finish", $time);
        wrap_up();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        seed = 32'hf55d;
        rstn_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        slow = 1'b0;
        err_count = 0;
        checked = 0;
        cyc = 0;
        repeat (10) @(posedge clk_sys_i);
        #1;
        check_bit(1'b1, pins_o.ras_n, "row strobe in reset");
        check_bit(1'b0, init_done_o, "init flag in reset");
        rstn_i = 1'b1;
        n = 0;
        while (init_done_o !== 1'b1 && n < 2000) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        check_bit(1'b1, init_done_o, "init completes");
        check_int(8, refresh_count, "init refresh cycles");
        t0 = cyc;
        // random mix over a few rows: a read to the same row right after a read hits the page window
        for (int i = 0; i < 300; i++) begin
            slow = 1'($random(seed));
            send(dpm_op_type'($unsigned($random(seed)) % 3), rows[$unsigned($random(seed)) % 4],
                 $unsigned($random(seed)) % 1024, 1'($random(seed)));
            if ($unsigned($random(seed)) % 5 == 0) begin
                req_valid_i = 1'b0;
                // at least one edge, so valid is never lowered and raised in one step
                repeat (1 + $unsigned($random(seed)) % 300) @(posedge clk_sys_i);
                #1;
            end
        end
        req_valid_i = 1'b0;
        repeat (4 * REF_CYC) @(posedge clk_sys_i);
        #1;
        check_int(0, exp_q.size(), "reads left unanswered");
        check_int(1, int'(refresh_count - 8 >= (cyc - t0) / REF_CYC - 1), "refresh rate");
        check_int(0, proto_err, "write-back before read data");
        wrap_up();
    end

endmodule // dpm_ctrl_tb
`default_nettype wire
